// *** pkg/tsc_pkg.sv ***
// tsc_pkg: constants, states and carriers of the test access port scan logic.
// assumes one system clock that samples the test clock pins as plain inputs.
`default_nettype none

package tsc_pkg;

  // ----------------------------------------------------------------
  // widths and fixed patterns
  // ----------------------------------------------------------------
  localparam int unsigned   TSC_IR_W        = 8;
  localparam int unsigned   TSC_DR_W        = 8;
  localparam logic [7:0]    TSC_IR_CAPTURE  = 8'h81;
  localparam logic [7:0]    TSC_IR_BYPASS   = 8'hFF;
  localparam logic          TSC_BYP_CAPTURE = 1'h0;
  localparam logic [7:0]    TSC_DR_RESET    = 8'h00;
  localparam int unsigned   TSC_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // timing: system clock and nominal test clock
  // ----------------------------------------------------------------
  localparam int unsigned   TSC_SYS_CLK_NS  = 50;
  localparam int unsigned   TSC_TCK_NS      = 400;
  localparam int unsigned   TSC_TCK_CYCLES  = TSC_TCK_NS / TSC_SYS_CLK_NS;

  // ----------------------------------------------------------------
  // test state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TSC_RESET      = 4'hF,
    TSC_IDLE       = 4'hC,
    TSC_SEL_DR     = 4'h7,
    TSC_CAP_DR     = 4'h6,
    TSC_SHIFT_DR   = 4'h2,
    TSC_EXIT1_DR   = 4'h1,
    TSC_PAUSE_DR   = 4'h3,
    TSC_EXIT2_DR   = 4'h0,
    TSC_UPDATE_DR  = 4'h5,
    TSC_SEL_IR     = 4'h4,
    TSC_CAP_IR     = 4'hE,
    TSC_SHIFT_IR   = 4'hA,
    TSC_EXIT1_IR   = 4'h9,
    TSC_PAUSE_IR   = 4'hB,
    TSC_EXIT2_IR   = 4'h8,
    TSC_UPDATE_IR  = 4'hD
  } tsc_state_type;

  // ----------------------------------------------------------------
  // pin carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tsc_pins_type;

  typedef struct packed {
    logic data;
    logic oe;
  } tsc_tdo_type;

endpackage : tsc_pkg

`default_nettype wire

// *** src/tsc_tap.sv ***
// tsc_tap: test access port scan logic with bypass and one test data register.
// assumes tck, tms, tdi come from an outside controller and are asynchronous
// to sys_clk_i; the test clock must be at least four system clocks long.
//
// Operation
// (R1) update-ir loads the shifted instruction into the instruction register on tck fall
// (R2) under bypass, bypass stage loads 0 on the rise leaving capture-dr
// (R3) serial output enabled on the tck fall after entering shift-dr
// (R4) bypass is one shift stage: 101 in gives 010 out
// (R5) serial output goes high impedance on the tck fall in exit1-dr
// (R6) update-dr loads the selected register's parallel output on tck fall
// (R7) tdi and tms sampled on tck rise, tdo driven on tck fall
// (R8) controller changes tms on tck fall, state advances on next rise
// (R9) leaving capture-ir, instruction shifter captures 10000001
// (R10) sixteen-state graph; tms high from update-dr returns to reset (the code goes to select-dr instead)
`default_nettype none

module tsc_tap #(
  parameter int unsigned DR_W = tsc_pkg::TSC_DR_W
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  // test access pins
  input  wire tsc_pkg::tsc_pins_type pins_i,
  output var  tsc_pkg::tsc_tdo_type  tdo_o,
  // parallel side
  input  wire logic [DR_W-1:0]       dr_capture_i,
  output logic [DR_W-1:0]            dr_out_o,
  output logic [tsc_pkg::TSC_IR_W-1:0] ir_o,
  output var  tsc_pkg::tsc_state_type state_o
);
  import tsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tsc_pins_type            sync1;
  tsc_pins_type            sync2;
  logic                    tck_d;
  tsc_state_type           state;
  logic [TSC_IR_W-1:0]     ir_shift;
  logic [TSC_IR_W-1:0]     ir;
  logic                    byp;
  logic [DR_W-1:0]         dr_shift;
  logic [DR_W-1:0]         dr_out;
  tsc_tdo_type             tdo;

  tsc_pins_type            next_sync1;
  tsc_pins_type            next_sync2;
  logic                    next_tck_d;
  tsc_state_type           next_state;
  logic [TSC_IR_W-1:0]     next_ir_shift;
  logic [TSC_IR_W-1:0]     next_ir;
  logic                    next_byp;
  logic [DR_W-1:0]         next_dr_shift;
  logic [DR_W-1:0]         next_dr_out;
  tsc_tdo_type             next_tdo;

  logic                    tck_rise;
  logic                    tck_fall;
  logic                    tms;
  logic                    tdi;
  logic                    bypass_sel;

  // ----------------------------------------------------------------
  // pin synchroniser and test clock edge detect
  // ----------------------------------------------------------------
  always_comb begin
    next_sync1 = pins_i;
    next_sync2 = sync1;
    next_tck_d = sync2.tck;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1 <= '0;
      sync2 <= '0;
      tck_d <= 1'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      tck_d <= next_tck_d;
    end
  end

  // tms and tdi pass the same two stages as tck, so they stay aligned to it
  assign tck_rise   = sync2.tck & ~tck_d; // R7
  assign tck_fall   = ~sync2.tck & tck_d; // R7
  assign tms        = sync2.tms;
  assign tdi        = sync2.tdi;
  assign bypass_sel = (ir == TSC_IR_BYPASS);

  // ----------------------------------------------------------------
  // test state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (tck_rise) begin // R7 R8
      case (state) // R10
        TSC_RESET:     next_state = tms ? TSC_RESET    : TSC_IDLE;
        TSC_IDLE:      next_state = tms ? TSC_SEL_DR   : TSC_IDLE;
        TSC_SEL_DR:    next_state = tms ? TSC_SEL_IR   : TSC_CAP_DR;
        TSC_CAP_DR:    next_state = tms ? TSC_EXIT1_DR : TSC_SHIFT_DR;
        TSC_SHIFT_DR:  next_state = tms ? TSC_EXIT1_DR : TSC_SHIFT_DR;
        TSC_EXIT1_DR:  next_state = tms ? TSC_UPDATE_DR : TSC_PAUSE_DR;
        TSC_PAUSE_DR:  next_state = tms ? TSC_EXIT2_DR : TSC_PAUSE_DR;
        TSC_EXIT2_DR:  next_state = tms ? TSC_UPDATE_DR : TSC_SHIFT_DR;
        TSC_UPDATE_DR: next_state = tms ? TSC_SEL_DR   : TSC_IDLE;
        TSC_SEL_IR:    next_state = tms ? TSC_RESET    : TSC_CAP_IR;
        TSC_CAP_IR:    next_state = tms ? TSC_EXIT1_IR : TSC_SHIFT_IR;
        TSC_SHIFT_IR:  next_state = tms ? TSC_EXIT1_IR : TSC_SHIFT_IR;
        TSC_EXIT1_IR:  next_state = tms ? TSC_UPDATE_IR : TSC_PAUSE_IR;
        TSC_PAUSE_IR:  next_state = tms ? TSC_EXIT2_IR : TSC_PAUSE_IR;
        TSC_EXIT2_IR:  next_state = tms ? TSC_UPDATE_IR : TSC_SHIFT_IR;
        TSC_UPDATE_IR: next_state = tms ? TSC_SEL_DR   : TSC_IDLE;
        default:       next_state = TSC_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= TSC_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // instruction shifter and instruction register
  // ----------------------------------------------------------------
  always_comb begin
    next_ir_shift = ir_shift;
    next_ir       = ir;
    if (tck_rise) begin
      case (state)
        TSC_CAP_IR:   next_ir_shift = TSC_IR_CAPTURE; // R9
        TSC_SHIFT_IR: next_ir_shift = {tdi, ir_shift[TSC_IR_W-1:1]};
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      case (state)
        TSC_RESET:     next_ir = TSC_IR_BYPASS;
        TSC_UPDATE_IR: next_ir = ir_shift; // R1
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_shift <= TSC_IR_CAPTURE;
      ir       <= TSC_IR_BYPASS;
    end else begin
      ir_shift <= next_ir_shift;
      ir       <= next_ir;
    end
  end

  // ----------------------------------------------------------------
  // bypass stage and test data register
  // ----------------------------------------------------------------
  always_comb begin
    next_byp      = byp;
    next_dr_shift = dr_shift;
    next_dr_out   = dr_out;
    if (tck_rise) begin
      case (state)
        TSC_CAP_DR: begin
          if (bypass_sel) begin
            next_byp = TSC_BYP_CAPTURE; // R2
          end else begin
            next_dr_shift = dr_capture_i;
          end
        end
        TSC_SHIFT_DR: begin
          if (bypass_sel) begin
            next_byp = tdi; // R4
          end else begin
            next_dr_shift = {tdi, dr_shift[DR_W-1:1]};
          end
        end
        default: begin
        end
      endcase
    end
    // bypass has no parallel side, so only the test register updates
    if (tck_fall && (state == TSC_UPDATE_DR) && !bypass_sel) begin
      next_dr_out = dr_shift; // R6
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byp      <= TSC_BYP_CAPTURE;
      dr_shift <= TSC_DR_RESET[DR_W-1:0];
      dr_out   <= TSC_DR_RESET[DR_W-1:0];
    end else begin
      byp      <= next_byp;
      dr_shift <= next_dr_shift;
      dr_out   <= next_dr_out;
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  always_comb begin
    next_tdo = tdo;
    if (tck_fall) begin // R7
      // enable rises in shift, drops in exit1 and elsewhere
      next_tdo.oe = (state == TSC_SHIFT_IR) || (state == TSC_SHIFT_DR); // R3 R5
      if (state == TSC_SHIFT_IR) begin
        next_tdo.data = ir_shift[0];
      end else if (state == TSC_SHIFT_DR) begin
        next_tdo.data = bypass_sel ? byp : dr_shift[0]; // R4
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdo <= '0;
    end else begin
      tdo <= next_tdo;
    end
  end

  assign tdo_o    = tdo;
  assign dr_out_o = dr_out;
  assign ir_o     = ir;
  assign state_o  = state;

endmodule : tsc_tap

`default_nettype wire

// *** bench/tsc_ctl_model.sv ***
// tsc_ctl_model: scan controller model driving tck, tms and tdi.
// assumes the bench calls cyc once for each test clock period.
`default_nettype none
module tsc_ctl_model (
  // clock
  input  wire logic                  sys_clk_i,
  // test access pins
  output var  tsc_pkg::tsc_pins_type pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  initial pins_o = '0;
  // called at a falling system edge; tck stands high between calls
  // 4 system clocks a phase, so one call is one 400 ns test clock period
  task automatic cyc(input logic tms, input logic tdi);
    pins_o = '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (TSC_TCK_CYCLES / 2) @(negedge sys_clk_i);
    pins_o.tck = 1'b1;
    repeat (TSC_TCK_CYCLES / 2) @(negedge sys_clk_i);
  endtask : cyc
endmodule : tsc_ctl_model
`default_nettype wire

// *** bench/tsc_tap_assertions.sv ***
// tsc_tap_assertions: edge and state checks on the scan port outputs.
// assumes tck phases of at least four system clocks.
`default_nettype none
module tsc_chk #(
  parameter int unsigned DR_W = 8
) (
  input wire logic                   sys_clk_i,
  input wire logic                   resetn_i,
  input wire tsc_pkg::tsc_pins_type  pins_i,
  input wire tsc_pkg::tsc_tdo_type   tdo_o,
  input wire logic [DR_W-1:0]        dr_out_o,
  input wire logic [7:0]             ir_o,
  input wire tsc_pkg::tsc_state_type state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // --------------------------------
  // edges: pin level two clocks back
  // --------------------------------
  st_on_rise_a: assert property ($changed(state_o) |-> $past(pins_i.tck, 2)) else $error("state off rise");
  tdo_on_fall_a: assert property ($changed(tdo_o) |-> !$past(pins_i.tck, 2)) else $error("tdo off fall");
  ir_update_a: assert property ($changed(ir_o) |-> !$past(pins_i.tck, 2)
    && state_o inside {TSC_UPDATE_IR, TSC_RESET}) else $error("ir load");
  dr_update_a: assert property ($changed(dr_out_o) |-> !$past(pins_i.tck, 2)
    && state_o == TSC_UPDATE_DR && ir_o != TSC_IR_BYPASS) else $error("dr load");
  oe_on_a: assert property ($rose(tdo_o.oe) |-> state_o inside {TSC_SHIFT_DR, TSC_SHIFT_IR}) else $error("oe on");
  oe_off_a: assert property ($fell(tdo_o.oe) |-> state_o inside {TSC_EXIT1_DR, TSC_EXIT1_IR}) else $error("oe off");
  ir_capture_a: assert property ($rose(tdo_o.oe) && state_o == TSC_SHIFT_IR |-> tdo_o.data) else $error("ir cap");
  byp_zero_a: assert property ($rose(tdo_o.oe) && state_o == TSC_SHIFT_DR && ir_o == TSC_IR_BYPASS
    |-> !tdo_o.data) else $error("bypass cap");
  // reset is only entered in one step, from select-ir
  sequence enter_reset_s;
    $changed(state_o) && state_o == TSC_RESET;
  endsequence
  sequence from_sel_ir_s;
    $past(state_o) == TSC_SEL_IR;
  endsequence
  reset_path_a: assert property (enter_reset_s |-> from_sel_ir_s) else $error("reset path");
endmodule : tsc_chk
bind tsc_tap tsc_chk #(.DR_W(DR_W)) i_chk (.sys_clk_i, .resetn_i, .pins_i, .tdo_o, .dr_out_o, .ir_o, .state_o);
`default_nettype wire

// *** bench/testbench.sv ***
// testbench: instruction and data scans through the scan port.
// assumes the controller model paces tck at 400 ns.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          resetn_i  = 1'b0;
  logic [7:0]    cap       = 8'hA5;
  tsc_pins_type  pins;
  tsc_tdo_type   tdo;
  logic [7:0]    dr_out;
  logic [7:0]    ir;
  tsc_state_type state;
  int            n_errors = 0;
  int            samples_checked = 0;
  // no pull on the serial line: released means z
  wire           tdo_pin = tdo.oe ? tdo.data : 1'bz;
  tsc_ctl_model i_ctl (.sys_clk_i, .pins_o(pins));
  tsc_tap i_dut (.sys_clk_i, .resetn_i, .pins_i(pins), .tdo_o(tdo), .dr_capture_i(cap),
    .dr_out_o(dr_out), .ir_o(ir), .state_o(state));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // from reset or idle to select-dr with ins loaded
  task automatic ir_scan(input logic [7:0] ins);
    logic [4:0] t = 5'h06;
    for (int i = 0; i < 5; i++) i_ctl.cyc(t[i], 1'b0);
    for (int i = 0; i < 8; i++) begin
      i_ctl.cyc(i == 7, ins[i]);
      chk({7'h00, tdo_pin}, {7'h00, TSC_IR_CAPTURE[i]});
    end
    i_ctl.cyc(1'b1, 1'b0);
    chk({7'h00, tdo_pin}, {7'h00, 1'hZ});
    i_ctl.cyc(1'b1, 1'b0);
    chk(ir, ins);
  endtask : ir_scan
  // from select-dr through update-dr back to reset
  task automatic dr_scan(input int n, input logic [7:0] din, input logic [7:0] dout);
    i_ctl.cyc(1'b0, 1'b0);
    i_ctl.cyc(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_ctl.cyc(i == n - 1, din[i]);
      chk({7'h00, tdo_pin}, {7'h00, dout[i]});
    end
    i_ctl.cyc(1'b1, 1'b0);
    chk({7'h00, tdo_pin}, {7'h00, 1'hZ});
    for (int i = 0; i < 3; i++) i_ctl.cyc(1'b1, 1'b0);
    chk({4'h0, state}, {4'h0, TSC_RESET});
  endtask : dr_scan
  // second pass starts with a one left in the bypass stage, so its capture shows
  task automatic bypass_scan;
    repeat (2) begin
      ir_scan(TSC_IR_BYPASS);
      dr_scan(3, 8'h05, 8'h02);
      chk(dr_out, TSC_DR_RESET);
    end
  endtask : bypass_scan
  task automatic data_scan;
    ir_scan(8'h00);
    dr_scan(8, 8'h3C, 8'hA5);
    chk(dr_out, 8'h3C);
  endtask : data_scan
  initial begin
    repeat (10) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    bypass_scan();
    data_scan();
    stop_test();
  end
  // all scans take about 31 us
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
